// ==== dv/ect_pulse_src.sv ====
`timescale 1ns/1ps
// ****
// external pulse source on the counter pin
// ****
module ect_pulse_src
(
    input  wire mclk,
    output reg  timer_input_pin
);
    reg idle_q = 1'b0;
    initial timer_input_pin = 1'b0;
    // park the pin; also the level between pulses
    task automatic park(input reg lvl);
    begin
        @(posedge mclk);
        idle_q <= lvl;
        timer_input_pin <= lvl;
    end
    endtask
    // active level held w cycles, idle level w+1 between pulses, far beyond one counter clock
    task automatic pulses(input int n, input int w);
    begin
        repeat (n)
        begin
            @(posedge mclk);
            timer_input_pin <= !idle_q;
            repeat (w) @(posedge mclk);
            timer_input_pin <= idle_q;
            repeat (w) @(posedge mclk);
        end
    end
    endtask
endmodule

// ==== dv/ect_timer_props.sv ====
`timescale 1ns/1ps
`include "ect_consts.vh"
// ****
// shadowed control state and timing checks
// ****
module ect_timer_props
(
    input wire        mclk,
    input wire        resetn,
    input wire        hsel,
    input wire [11:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire [31:0] hwdata,
    input wire [31:0] hrdata,
    input wire        timer_input_pin,
    input wire        stop_mode_entry,
    input wire        counter_interrupt
);
    reg        wr_q, rd_q, pin_q, pol_q;
    reg [11:0] a_q;
    reg [7:0]  ctl_q;
    reg [4:0]  edg_q, off_q;
    wire       ev;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    assign ev = !ctl_q[`ECT_CTRL_MODE_BIT] &&
                ctl_q[`ECT_CTRL_CK_LSB+2:`ECT_CTRL_CK_LSB] == `ECT_CK_EXT;
    // shadow what software wrote; edge and stop ages saturate at 31
    always @(posedge mclk)
    begin
        if (!resetn)
        begin
            {wr_q, rd_q, pol_q, a_q, ctl_q, off_q} <= 0;
            pin_q <= timer_input_pin;
            edg_q <= 5'h1f;
        end
        else
        begin
            wr_q <= hsel && hready && htrans[1] && hwrite;
            rd_q <= hsel && hready && htrans[1] && !hwrite;
            a_q <= haddr;
            pin_q <= timer_input_pin;
            edg_q <= (pin_q != timer_input_pin) ? 5'h0 : edg_q + (edg_q != 5'h1f);
            off_q <= ctl_q[4] ? 5'h0 : off_q + (off_q != 5'h1f);
            if (wr_q && a_q == `ECT_ADDR_CTRL) ctl_q <= hwdata[7:0];
            if (stop_mode_entry) ctl_q[4] <= 1'b0; // stop wins over a write
            if (wr_q && a_q == `ECT_ADDR_EDGE) pol_q <= hwdata[0];
        end
    end
    property p_irq_pulse; counter_interrupt |=> !counter_interrupt;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("interrupt wider than one cycle");
    property p_ev_near; counter_interrupt && ev |-> edg_q <= 5'd10;
    endproperty
    a_ev_near: assert property (p_ev_near)
        else $error("event interrupt without a recent pin edge");
    property p_ev_level; counter_interrupt && ev |-> timer_input_pin == pol_q;
    endproperty
    a_ev_level: assert property (p_ev_level)
        else $error("event interrupt on the counting edge");
    property p_quiet; off_q >= 5'd8 |-> !counter_interrupt;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("interrupt while stopped");
    property p_stop; stop_mode_entry [*6] |-> !counter_interrupt;
    endproperty
    a_stop: assert property (p_stop)
        else $error("interrupt during stop mode");
    property p_pol_rd; rd_q && a_q == `ECT_ADDR_EDGE |-> hrdata[0] == pol_q;
    endproperty
    a_pol_rd: assert property (p_pol_rd)
        else $error("polarity read back wrong");
    property p_mode_rd;
        rd_q && a_q == `ECT_ADDR_CTRL |->
            hrdata[`ECT_CTRL_MODE_BIT] == ctl_q[`ECT_CTRL_MODE_BIT];
    endproperty
    a_mode_rd: assert property (p_mode_rd)
        else $error("mode bit read back wrong");
    property p_ck_rd;
        rd_q && a_q == `ECT_ADDR_CTRL |->
            hrdata[4:0] == ctl_q[4:0] && hrdata[6] == ctl_q[6];
    endproperty
    a_ck_rd: assert property (p_ck_rd)
        else $error("clock select read back wrong");
    c_ev_irq: cover property (counter_interrupt && ev);
    c_cap_irq: cover property (counter_interrupt && ctl_q[`ECT_CTRL_MODE_BIT]);
    c_stop: cover property (stop_mode_entry && ctl_q[4]);
endmodule
bind ect_timer ect_timer_props ect_timer_props_inst (.mclk(mclk),
    .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .timer_input_pin(timer_input_pin), .stop_mode_entry(stop_mode_entry),
    .counter_interrupt(counter_interrupt));

// ==== dv/edge_counter_capture_timer_tb.sv ====
`timescale 1ns/1ps
`include "ect_consts.vh"
// ****
// bus-level tests of the edge counter / capture timer
// ****
module edge_counter_capture_timer_tb;
    reg         mclk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    reg  [11:0] haddr = 12'h000;
    reg  [1:0]  htrans = 2'h0;
    reg  [31:0] hwdata = 32'h0, rd;
    reg         stop_mode_entry = 1'b0;
    wire [31:0] hrdata;
    wire        hreadyout, pin, irq;
    int         err_total = 0, checks_done = 0, irq_n = 0, irq0;
    always #20 mclk = !mclk;
    // interrupt pulses counted at the edge that sees them
    always @(posedge mclk) irq_n <= irq_n + (irq === 1'b1);
    ect_timer ect_timer_inst (.mclk(mclk), .resetn(resetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(), .timer_input_pin(pin),
        .stop_mode_entry(stop_mode_entry), .counter_interrupt(irq));
    ect_pulse_src ect_pulse_src_inst (.mclk(mclk), .timer_input_pin(pin));
    // one single-word transfer; read data taken at the data phase edge
    task automatic bus(input [11:0] a, input wr, input [31:0] d);
    begin
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        rd = hrdata;
    end
    endtask
    task automatic cmp(input string n, input [31:0] e, input [31:0] g);
    begin
        checks_done++;
        if (e !== g)
        begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    end
    endtask
    task automatic rdc(input string n, input [11:0] a, input [31:0] e);
    begin
        bus(a, 1'b0, 32'h0);
        cmp(n, e, rd & 32'hff);
    end
    endtask
    // window check: prescaler phase is free-running, so ticks vary by one
    task automatic rd_in(input string n, input [11:0] a, input [7:0] lo,
                         input [7:0] hi);
    begin
        bus(a, 1'b0, 32'h0);
        checks_done++;
        if ((rd[7:0] >= lo && rd[7:0] <= hi) !== 1'b1)
        begin
            err_total++;
            $display("CHECK FAILED %s exp %h..%h got %h", n, lo, hi, rd);
        end
    end
    endtask
    task automatic give_verdict;
    begin
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    initial
    begin
        repeat (80000) @(posedge mclk);
        err_total++;
        give_verdict;
    end
    // ****
    // main sequence
    // ****
    initial
    begin
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        rdc("capb reset", `ECT_ADDR_CAPB, 32'hff);
        rdc("unmapped", 12'h020, 32'h0);
        for (int p = 0; p < 2; p++)
        begin
            bus(`ECT_ADDR_CTRL, 1'b1, 32'h0e);
            bus(`ECT_ADDR_EDGE, 1'b1, p);
            ect_pulse_src_inst.park(p[0]);
            bus(`ECT_ADDR_CMPA, 1'b1, 32'h03);
            bus(`ECT_ADDR_CTRL, 1'b1, 32'h5e);
            rdc("polarity", `ECT_ADDR_EDGE, p);
            irq0 = irq_n;
            ect_pulse_src_inst.pulses(2, 12);
            rdc("live count", `ECT_ADDR_CAPB, 32'h02);
            rdc("count", `ECT_ADDR_STAT, 32'h02);
            ect_pulse_src_inst.pulses(1, 12);
            cmp("match irq", irq0 + 1, irq_n);
            rdc("no zero capture", `ECT_ADDR_CAPB, 32'h03);
            rdc("cleared", `ECT_ADDR_STAT, 32'h00);
            ect_pulse_src_inst.pulses(1, 12);
            rdc("resumed", `ECT_ADDR_STAT, 32'h01);
            $display("test event polarity %0d done", p);
        end
        stop_mode_entry <= 1'b1;
        repeat (8) @(posedge mclk);
        stop_mode_entry <= 1'b0;
        bus(`ECT_ADDR_CTRL, 1'b0, 32'h0);
        cmp("run bit", 32'h0, {31'h0, rd[4]});
        ect_pulse_src_inst.pulses(2, 12);
        rdc("held", `ECT_ADDR_STAT, 32'h00);
        $display("test stop mode done");
        bus(`ECT_ADDR_CTRL, 1'b1, 32'h0c);
        bus(`ECT_ADDR_EDGE, 1'b1, 32'h0);
        ect_pulse_src_inst.park(1'b0);
        // let the parked fall pass the synchroniser before starting
        repeat (8) @(posedge mclk);
        bus(`ECT_ADDR_CTRL, 1'b1, 32'h1d);
        irq0 = irq_n;
        repeat (1280) @(posedge mclk);
        ect_pulse_src_inst.park(1'b1);
        repeat (8) @(posedge mclk);
        cmp("first rise irq", irq0 + 1, irq_n);
        rdc("b keeps last", `ECT_ADDR_CAPB, 32'h01);
        rd_in("a on rise", `ECT_ADDR_CMPA, 8'h04, 8'h06);
        repeat (768) @(posedge mclk);
        ect_pulse_src_inst.park(1'b0);
        repeat (768) @(posedge mclk);
        ect_pulse_src_inst.park(1'b1);
        repeat (8) @(posedge mclk);
        cmp("second irq", irq0 + 2, irq_n);
        rd_in("b on fall", `ECT_ADDR_CAPB, 8'h02, 8'h04);
        rd_in("a period", `ECT_ADDR_CMPA, 8'h05, 8'h07);
        $display("test capture done");
        // pin idles high: 256 ticks of 256 cycles end in an overflow
        irq0 = irq_n;
        repeat (66000) @(posedge mclk);
        cmp("overflow irq", irq0 + 1, irq_n);
        repeat (1300) @(posedge mclk);
        ect_pulse_src_inst.park(1'b0);
        repeat (300) @(posedge mclk);
        ect_pulse_src_inst.park(1'b1);
        repeat (8) @(posedge mclk);
        cmp("suspended irq", irq0 + 1, irq_n);
        bus(`ECT_ADDR_STAT, 1'b0, 32'h0);
        cmp("suspend flag", 32'h1, {31'h0, rd[9]});
        rd_in("b not reloaded", `ECT_ADDR_CAPB, 8'h02, 8'h04);
        rdc("a overflow", `ECT_ADDR_CMPA, 32'hff);
        bus(`ECT_ADDR_STAT, 1'b0, 32'h0);
        cmp("resume flag", 32'h0, {31'h0, rd[9]});
        ect_pulse_src_inst.park(1'b0);
        repeat (300) @(posedge mclk);
        ect_pulse_src_inst.park(1'b1);
        repeat (8) @(posedge mclk);
        cmp("resumed irq", irq0 + 2, irq_n);
        $display("test overflow done");
        give_verdict;
    end
endmodule

// ==== rtl/ect_consts.vh ====
// Functional notes
// - event mode counts each selected input edge
// - event mode compare match raises interrupt and clears counter
// - event compare match is detected on the opposite edge
// - auto-capture copies live count into capture register b
// - zero after a compare clear is not auto-captured
// - capture mode counts on the prescaled internal clock
// - polarity 0: falling loads b, rising loads a, interrupts, clears
// - polarity 1: rising loads b, falling loads a, interrupts, clears
// - after a capture clear counting continues, next b edge reloads b
// - first edge of a-polarity loads a only; b keeps value, ff at reset
// - capture overflow at ff interrupts, loads ff into a, clears
// - after overflow capture and overflow stop until a is read
// - mode bit 0 is timer/event counter, 1 is capture
// - clock select 111 routes the input pin as counter clock
// - stop mode entry clears the run bit
`ifndef ECT_CONSTS_VH
`define ECT_CONSTS_VH

// ***************************************************
// register byte addresses
// ***************************************************
`define ECT_ADDR_CTRL      12'h000
`define ECT_ADDR_EDGE      12'h004
`define ECT_ADDR_CMPA      12'h008
`define ECT_ADDR_CAPB      12'h00c
`define ECT_ADDR_STAT      12'h010

// ***************************************************
// control register fields
// ***************************************************
`define ECT_CTRL_CK_LSB    1
`define ECT_CTRL_MODE_BIT  0
`define ECT_CTRL_RUN_BIT   4
`define ECT_CTRL_AUTO_CAPTURE_ENABLE_BIT  6
`define ECT_CK_EXT         3'h7

// ***************************************************
// reset values and prescaler taps
// ***************************************************
`define ECT_CAP_RESET      8'hff
`define ECT_CNT_MAX        8'hff
`define ECT_PRE_BASE       5

`endif

// ==== rtl/ect_prescaler.v ====
`timescale 1ns/1ps
`include "ect_consts.vh"
// ***************************************************
// free-running divider, one-cycle tick on the chosen tap
// ***************************************************
module ect_prescaler
#(
    parameter WIDTH = 14
)
(
    input  wire       mclk,
    input  wire       resetn,
    input  wire [2:0] tap_sel,
    output reg        tick
);
    reg  [WIDTH-1:0] div_q;
    wire [WIDTH-1:0] div_d;
    reg  [3:0]       bitpos;

    assign div_d = div_q + {{(WIDTH-1){1'b0}}, 1'b1};

    // tap 000 is the slowest; codes up to 110 each halve the period, 111 gives the same period as 110
    always @*
    begin
        bitpos = 4'h0;
        case (tap_sel)
            3'h0: bitpos = 4'hd;
            3'h1: bitpos = 4'hc;
            3'h2: bitpos = 4'hb;
            3'h3: bitpos = 4'ha;
            3'h4: bitpos = 4'h9;
            3'h5: bitpos = 4'h8;
            3'h6: bitpos = 4'h7;
            default: bitpos = 4'h7;
        endcase
    end

    // rising carry into the tap bit gives one pulse per period
    always @(posedge mclk)
    begin
        if (!resetn)
        begin
            div_q <= {WIDTH{1'b0}};
            tick  <= 1'b0;
        end
        else
        begin
            div_q <= div_d;
            tick  <= div_d[bitpos] & ~div_q[bitpos];
        end
    end
endmodule

// ==== rtl/ect_timer.v ====
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "ect_consts.vh"
// ***************************************************
// edge counter / capture timer with ahb-lite slave
// ***************************************************
module ect_timer
(
    input  wire        mclk,
    input  wire        resetn,
    input  wire        hsel,
    input  wire [11:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire        timer_input_pin,
    input  wire        stop_mode_entry,
    output reg         counter_interrupt
);
    // ***************************************************
    // registers
    // ***************************************************
    reg  [2:0]  counter_clock_select_q;
    reg         counter_mode_select_q;
    reg         counter_run_bit_q;
    reg         auto_capture_enable_q;
    reg         edge_polarity_select_q;
    reg  [7:0]  compare_capture_reg_a_q;
    reg  [7:0]  capture_reg_b_q;
    reg  [7:0]  count_q;
    reg         susp_q;       // overflow suspend in capture mode
    reg         cleared_q;    // count zero came from a match clear
    reg         pend_q;       // count reached compare, waiting opposite edge, or one cycle on internal clock
    reg  [2:0]  pin_sync_q;
    reg         pin_last_q;
    reg         ph_q;         // pending data phase
    reg         ph_wr_q;
    reg  [11:0] ph_addr_q;
    reg         irq_q;

    wire        tick;
    wire        pin_stable;
    wire        pin_rise;
    wire        pin_fall;
    wire        ext_clk;
    wire        sel_edge;
    wire        opp_edge;
    wire        cnt_en;
    wire        rd_a;
    wire [7:0]  count_inc;

    ect_prescaler #(.WIDTH(14)) u_pre
    (
        .mclk    (mclk),
        .resetn  (resetn),
        .tap_sel (counter_clock_select_q),
        .tick    (tick)
    );

    // ***************************************************
    // input synchroniser and edge detect
    // ***************************************************
    // stage 0 is only read by stage 1; change accepted when 1 and 2 agree
    always @(posedge mclk)
    begin
        if (!resetn)
        begin
            pin_sync_q <= 3'h0;
            pin_last_q <= 1'b0;
        end
        else
        begin
            pin_sync_q <= {pin_sync_q[1:0], timer_input_pin};
            if (pin_stable)
                pin_last_q <= pin_sync_q[1];
        end
    end

    assign pin_stable = (pin_sync_q[1] == pin_sync_q[2]);
    assign pin_rise   = pin_stable & pin_sync_q[1] & ~pin_last_q;
    assign pin_fall   = pin_stable & ~pin_sync_q[1] & pin_last_q;

    // selected edge counts, opposite edge checks the compare
    assign sel_edge = edge_polarity_select_q ? pin_fall : pin_rise;
    assign opp_edge = edge_polarity_select_q ? pin_rise : pin_fall;
    assign ext_clk  = (counter_clock_select_q == `ECT_CK_EXT);
    // capture mode always counts internal ticks
    assign cnt_en   = (ext_clk && !counter_mode_select_q) ? sel_edge
                    : tick;
    assign count_inc = count_q + 8'h01;

    // ***************************************************
    // bus decode
    // ***************************************************
    assign rd_a = ph_q & ~ph_wr_q & (ph_addr_q == `ECT_ADDR_CMPA);

    // address phase captured, data phase answered next cycle, zero wait
    always @(posedge mclk)
    begin
        if (!resetn)
        begin
            ph_q      <= 1'b0;
            ph_wr_q   <= 1'b0;
            ph_addr_q <= 12'h000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else if (hready)
        begin
            ph_q      <= hsel & htrans[1];
            ph_wr_q   <= hwrite;
            ph_addr_q <= haddr;
        end
    end

    // read mux registered so hrdata comes from flops
    always @(posedge mclk)
    begin
        if (!resetn)
            hrdata <= 32'h00000000;
        else if (hready && hsel && htrans[1] && !hwrite)
        begin
            case (haddr)
                `ECT_ADDR_CTRL:
                    hrdata <= {25'h0, auto_capture_enable_q, 1'b0,
                               counter_run_bit_q, counter_clock_select_q,
                               counter_mode_select_q};
                `ECT_ADDR_EDGE: hrdata <= {31'h0, edge_polarity_select_q};
                `ECT_ADDR_CMPA: hrdata <= {24'h0, compare_capture_reg_a_q};
                `ECT_ADDR_CAPB: hrdata <= {24'h0, capture_reg_b_q};
                `ECT_ADDR_STAT: hrdata <= {22'h0, susp_q, pend_q, count_q};
                default:        hrdata <= 32'h00000000;
            endcase
        end
    end

    // ***************************************************
    // configuration writes
    // ***************************************************
    always @(posedge mclk)
    begin
        if (!resetn)
        begin
            counter_clock_select_q <= 3'h0;
            counter_mode_select_q  <= 1'b0;
            counter_run_bit_q      <= 1'b0;
            auto_capture_enable_q  <= 1'b0;
            edge_polarity_select_q <= 1'b0;
        end
        else
        begin
            if (ph_q && ph_wr_q && ph_addr_q == `ECT_ADDR_CTRL)
            begin
                counter_clock_select_q <= hwdata[`ECT_CTRL_CK_LSB+2:
                                                 `ECT_CTRL_CK_LSB];
                counter_mode_select_q  <= hwdata[`ECT_CTRL_MODE_BIT];
                counter_run_bit_q      <= hwdata[`ECT_CTRL_RUN_BIT];
                auto_capture_enable_q  <= hwdata[`ECT_CTRL_AUTO_CAPTURE_ENABLE_BIT];
            end
            if (ph_q && ph_wr_q && ph_addr_q == `ECT_ADDR_EDGE)
                edge_polarity_select_q <= hwdata[0];
            // stop mode wins over a same-cycle write
            if (stop_mode_entry)
                counter_run_bit_q <= 1'b0;
        end
    end

    // ***************************************************
    // counter, compare and capture engine
    // ***************************************************
    // register a: software compare in counter mode, capture in capture mode
    always @(posedge mclk)
    begin
        if (!resetn)
        begin
            count_q                 <= 8'h00;
            compare_capture_reg_a_q <= 8'h00;
            capture_reg_b_q         <= `ECT_CAP_RESET;
            susp_q                  <= 1'b0;
            cleared_q               <= 1'b0;
            pend_q                  <= 1'b0;
            irq_q                   <= 1'b0;
            counter_interrupt       <= 1'b0;
        end
        else
        begin
            irq_q             <= 1'b0;
            counter_interrupt <= irq_q;
            if (ph_q && ph_wr_q && ph_addr_q == `ECT_ADDR_CMPA)
                compare_capture_reg_a_q <= hwdata[7:0];
            if (!counter_run_bit_q)
            begin
                count_q   <= 8'h00;
                pend_q    <= 1'b0;
                cleared_q <= 1'b0;
                susp_q    <= 1'b0;
            end
            else if (!counter_mode_select_q)
            begin
                // timer / event counter mode
                if (cnt_en)
                begin
                    count_q   <= count_inc;
                    cleared_q <= 1'b0;
                end
                if (cnt_en && count_inc == compare_capture_reg_a_q)
                    pend_q <= 1'b1;
                if (pend_q && (ext_clk ? opp_edge : 1'b1))
                begin
                    irq_q     <= 1'b1;
                    count_q   <= 8'h00;
                    cleared_q <= 1'b1;
                    pend_q    <= 1'b0;
                end
                // live count into b, but not the zero after a match
                if (auto_capture_enable_q && !cleared_q &&
                    !(pend_q && (ext_clk ? opp_edge : 1'b1)))
                    capture_reg_b_q <= count_q;
            end
            else
            begin
                // capture mode
                if (tick)
                    count_q <= count_inc;
                if (!susp_q)
                begin
                    if (sel_edge)
                    begin
                        // polarity 0 selects rise: a-edge; b on fall
                        compare_capture_reg_a_q <= count_q;
                        irq_q   <= 1'b1;
                        count_q <= 8'h00;
                    end
                    else if (tick && count_q == `ECT_CNT_MAX)
                    begin
                        compare_capture_reg_a_q <= `ECT_CNT_MAX;
                        irq_q   <= 1'b1;
                        count_q <= 8'h00;
                        susp_q  <= 1'b1;
                    end
                    if (opp_edge)
                        capture_reg_b_q <= count_q;
                end
                // a read of register a resumes capture
                if (rd_a)
                    susp_q <= 1'b0;
            end
        end
    end
endmodule
